/* File: hdl/status_pkg.sv */
// Register map, field positions and reset values of the status and control register bank.
package status_pkg;
   // ---------------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------------
   localparam logic [7:0] OFF_IRQ_EN_LOCK_INPUTS = 8'h68;
   localparam logic [7:0] OFF_IRQ_EN_REFERENCE = 8'h69;
   localparam logic [7:0] OFF_STICKY_LOCK_INPUTS = 8'h6c;
   localparam logic [7:0] OFF_NOW_LOCK_INPUTS = 8'h6d;
   localparam logic [7:0] OFF_STICKY_REFERENCE = 8'h6e;
   localparam logic [7:0] OFF_NOW_REFERENCE_CAL = 8'h6f;
   localparam logic [7:0] OFF_DIVIDER_INIT = 8'h71;
   localparam logic [7:0] OFF_PLL_CMD_A = 8'h72;
   localparam logic [7:0] OFF_BIAS_CAL_POLARITY = 8'h73;
   // ---------------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------------
   localparam int BIT_SYNTH = 5;
   localparam int BIT_JITTER = 4;
   localparam int BIT_INPUT0 = 0;
   localparam int BIT_SEL_LO = 6;
   localparam int BIT_REF = 1;
   localparam int BIT_HOLD = 0;
   localparam int BIT_CAL_RUNNING = 2;
   localparam int BIT_COMMAND = 7;
   localparam int BIT_POLARITY = 0;
   // ---------------------------------------------------------------------
   // Widths and reset values
   // ---------------------------------------------------------------------
   localparam int NUM_INPUTS = 2;
   localparam int SEL_W = 2;
   localparam logic RST_IRQ_EN = 1'b0;
   localparam logic RST_FAULT = 1'b0;
   localparam logic RST_POLARITY = 1'b0;
   localparam logic [7:0] RDATA_IDLE = 8'h00;
   // Healthy view of the raw status: sel 00, locks 1, inputs active, cal idle, reference 1, no holdover, done 0.
   localparam logic [9:0] RST_RAW = 10'h0f6;
   localparam logic RST_REF_PREV = 1'b1;
endpackage

/* File: hdl/pll_status_interrupt_regs.sv */
// Status, interrupt and general control register bank behind the serial configuration port.
`timescale 1ns/10ps

// Notes on behaviour
// RULE_01 - Synth PLL unlock enabled pulls interrupt low.
// RULE_02 - Jitter PLL unlock enabled pulls interrupt low.
// RULE_03 - Input signal loss enabled pulls interrupt low.
// RULE_04 - Any reference change interrupts when enabled.
// RULE_05 - Holdover entry enabled pulls interrupt low.
// RULE_06 - Enables reset zero; disabled flags stay silent.
// RULE_07 - Synth lock sticky reads 0 after loss.
// RULE_08 - Jitter lock sticky reads 0 after loss.
// RULE_09 - Input sticky reads 0 after signal loss.
// RULE_10 - Reference sticky reads 0 after reference loss.
// RULE_11 - Holdover sticky reads 0 after holdover entry.
// RULE_12 - Selected input field shows current choice.
// RULE_13 - Momentary lock bits feed sticky flags.
// RULE_14 - Momentary input activity bit per input.
// RULE_15 - Calibration running bit reads one.
// RULE_16 - Reference present bit for selected input.
// RULE_17 - Momentary holdover bit reads 0 in holdover.
// RULE_18 - Divider init write pulses divider initialisation.
// RULE_19 - Pll_cmd_a write forces fresh lock acquisition.
// RULE_20 - Bias calibration bit clears when finished.
// RULE_21 - Polarity bit picks read shift edge.
// RULE_22 - Interrupt holds until enabled flags cleared.
module pll_status_interrupt_regs
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic synth_pll_lock_now_in,
   input wire logic jitter_pll_lock_now_in,
   input wire logic [status_pkg::NUM_INPUTS-1:0] input_active_now_in,
   input wire logic [status_pkg::SEL_W-1:0] selected_input_now_in,
   input wire logic synth_cal_running_in,
   input wire logic reference_present_now_in,
   input wire logic holdover_now_in,
   input wire logic bias_cal_done_in,
   output logic irq_n_out,
   output logic divider_init_out,
   output logic pll_cmd_a_out,
   output logic bias_cal_cmd_out,
   output logic read_edge_polarity_out
);

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   localparam int RAW_W = 10;

   typedef struct packed {
      logic [RAW_W-1:0] sync1;
      logic [RAW_W-1:0] sync2;
      logic ref_prev;
      logic done_prev;
      logic synth_pll_unlock_irq_en;
      logic jitter_pll_unlock_irq_en;
      logic [status_pkg::NUM_INPUTS-1:0] input_los_irq_en;
      logic reference_irq_en;
      logic holdover_irq_en;
      logic synth_fault;
      logic jitter_fault;
      logic [status_pkg::NUM_INPUTS-1:0] input_fault;
      logic ref_fault;
      logic ref_pend;
      logic hold_fault;
      logic init_pulse;
      logic pll_cmd_a_pulse;
      logic cal_start;
      logic cal_busy;
      logic polarity;
      logic [7:0] rdata;
      logic irq_n;
   } state_t;

   state_t st_q;
   state_t st_d;

   // Synchronised view of the raw status, named for readability.
   logic [status_pkg::SEL_W-1:0] sel_s;
   logic synth_lock_s;
   logic jitter_lock_s;
   logic [status_pkg::NUM_INPUTS-1:0] active_s;
   logic cal_run_s;
   logic ref_s;
   logic hold_s;
   logic done_s;

   assign sel_s = st_q.sync2[9:8];
   assign synth_lock_s = st_q.sync2[7];
   assign jitter_lock_s = st_q.sync2[6];
   assign active_s = st_q.sync2[5:4];
   assign cal_run_s = st_q.sync2[3];
   assign ref_s = st_q.sync2[2];
   assign hold_s = st_q.sync2[1];
   assign done_s = st_q.sync2[0];

   // ---------------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   function automatic logic [7:0] read_mux(input logic [7:0] addr, input state_t s);
      logic [7:0] v;
      v = status_pkg::RDATA_IDLE;
      case (addr)
         status_pkg::OFF_IRQ_EN_LOCK_INPUTS:
         begin
            v[status_pkg::BIT_SYNTH] = s.synth_pll_unlock_irq_en;
            v[status_pkg::BIT_JITTER] = s.jitter_pll_unlock_irq_en;
            v[status_pkg::BIT_INPUT0 +: status_pkg::NUM_INPUTS] = s.input_los_irq_en;
         end
         status_pkg::OFF_IRQ_EN_REFERENCE:
         begin
            v[status_pkg::BIT_REF] = s.reference_irq_en;
            v[status_pkg::BIT_HOLD] = s.holdover_irq_en;
         end
         status_pkg::OFF_STICKY_LOCK_INPUTS:
         begin
            // Sticky bits read 1 while nothing happened since the last clear.
            v[status_pkg::BIT_SYNTH] = ~s.synth_fault; // RULE_07
            v[status_pkg::BIT_JITTER] = ~s.jitter_fault; // RULE_08
            v[status_pkg::BIT_INPUT0 +: status_pkg::NUM_INPUTS] = ~s.input_fault; // RULE_09
         end
         status_pkg::OFF_NOW_LOCK_INPUTS:
         begin
            v[status_pkg::BIT_SEL_LO +: status_pkg::SEL_W] = s.sync2[9:8]; // RULE_12
            v[status_pkg::BIT_SYNTH] = s.sync2[7]; // RULE_13
            v[status_pkg::BIT_JITTER] = s.sync2[6]; // RULE_13
            v[status_pkg::BIT_INPUT0 +: status_pkg::NUM_INPUTS] = s.sync2[5:4]; // RULE_14
         end
         status_pkg::OFF_STICKY_REFERENCE:
         begin
            v[status_pkg::BIT_REF] = ~s.ref_fault; // RULE_10
            v[status_pkg::BIT_HOLD] = ~s.hold_fault; // RULE_11
         end
         status_pkg::OFF_NOW_REFERENCE_CAL:
         begin
            v[status_pkg::BIT_CAL_RUNNING] = s.sync2[3]; // RULE_15
            v[status_pkg::BIT_REF] = s.sync2[2]; // RULE_16
            v[status_pkg::BIT_HOLD] = s.sync2[1]; // RULE_17
         end
         status_pkg::OFF_BIAS_CAL_POLARITY:
         begin
            v[status_pkg::BIT_COMMAND] = s.cal_busy;
            v[status_pkg::BIT_POLARITY] = s.polarity;
         end
         default:
         begin
            v = status_pkg::RDATA_IDLE;
         end
      endcase
      read_mux = v;
   endfunction

   // ---------------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------------
   logic wr_lock_en;
   logic wr_ref_en;
   logic wr_lock_clr;
   logic wr_ref_clr;
   logic wr_init;
   logic wr_pll_cmd_a;
   logic wr_bias;
   logic [7:0] pending;

   always_comb
   begin
      wr_lock_en = reg_wr_in && hit(reg_addr_in, status_pkg::OFF_IRQ_EN_LOCK_INPUTS);
      wr_ref_en = reg_wr_in && hit(reg_addr_in, status_pkg::OFF_IRQ_EN_REFERENCE);
      wr_lock_clr = reg_wr_in && hit(reg_addr_in, status_pkg::OFF_STICKY_LOCK_INPUTS);
      wr_ref_clr = reg_wr_in && hit(reg_addr_in, status_pkg::OFF_STICKY_REFERENCE);
      wr_init = reg_wr_in && hit(reg_addr_in, status_pkg::OFF_DIVIDER_INIT);
      wr_pll_cmd_a = reg_wr_in && hit(reg_addr_in, status_pkg::OFF_PLL_CMD_A);
      wr_bias = reg_wr_in && hit(reg_addr_in, status_pkg::OFF_BIAS_CAL_POLARITY);

      st_d = st_q;
      st_d.sync1 = {selected_input_now_in, synth_pll_lock_now_in, jitter_pll_lock_now_in,
                    input_active_now_in, synth_cal_running_in, reference_present_now_in,
                    holdover_now_in, bias_cal_done_in};
      st_d.sync2 = st_q.sync1;
      st_d.ref_prev = ref_s;
      st_d.done_prev = done_s;

      if (wr_lock_en)
      begin
         st_d.synth_pll_unlock_irq_en = reg_wdata_in[status_pkg::BIT_SYNTH];
         st_d.jitter_pll_unlock_irq_en = reg_wdata_in[status_pkg::BIT_JITTER];
         st_d.input_los_irq_en = reg_wdata_in[status_pkg::BIT_INPUT0 +: status_pkg::NUM_INPUTS];
      end
      if (wr_ref_en)
      begin
         st_d.reference_irq_en = reg_wdata_in[status_pkg::BIT_REF];
         st_d.holdover_irq_en = reg_wdata_in[status_pkg::BIT_HOLD];
      end

      // A write of 1 clears a flag, but an event in the same cycle sets it again.
      if (wr_lock_clr && reg_wdata_in[status_pkg::BIT_SYNTH])
      begin
         st_d.synth_fault = 1'b0;
      end
      if (wr_lock_clr && reg_wdata_in[status_pkg::BIT_JITTER])
      begin
         st_d.jitter_fault = 1'b0;
      end
      for (int i = 0; i < status_pkg::NUM_INPUTS; i++)
      begin
         if (wr_lock_clr && reg_wdata_in[status_pkg::BIT_INPUT0 + i])
         begin
            st_d.input_fault[i] = 1'b0;
         end
         if (!active_s[i])
         begin
            st_d.input_fault[i] = 1'b1; // RULE_09
         end
      end
      if (wr_ref_clr && reg_wdata_in[status_pkg::BIT_REF])
      begin
         st_d.ref_fault = 1'b0;
         st_d.ref_pend = 1'b0;
      end
      if (wr_ref_clr && reg_wdata_in[status_pkg::BIT_HOLD])
      begin
         st_d.hold_fault = 1'b0;
      end

      if (!synth_lock_s)
      begin
         st_d.synth_fault = 1'b1; // RULE_07
      end
      if (!jitter_lock_s)
      begin
         st_d.jitter_fault = 1'b1; // RULE_08
      end
      if (!ref_s)
      begin
         st_d.ref_fault = 1'b1; // RULE_10
      end
      // Recovery of the reference is reported too, not only its loss.
      if (ref_s != st_q.ref_prev)
      begin
         st_d.ref_pend = 1'b1; // RULE_04
      end
      if (!hold_s)
      begin
         st_d.hold_fault = 1'b1; // RULE_11
      end

      st_d.init_pulse = wr_init && reg_wdata_in[status_pkg::BIT_COMMAND]; // RULE_18
      st_d.pll_cmd_a_pulse = wr_pll_cmd_a && reg_wdata_in[status_pkg::BIT_COMMAND]; // RULE_19
      st_d.cal_start = wr_bias && reg_wdata_in[status_pkg::BIT_COMMAND] && !st_q.cal_busy;
      if (wr_bias)
      begin
         st_d.polarity = reg_wdata_in[status_pkg::BIT_POLARITY]; // RULE_21
      end
      // Only a fresh rising edge of done ends a run, so a level left from the last run is ignored.
      if (st_d.cal_start)
      begin
         st_d.cal_busy = 1'b1; // RULE_20
      end
      else if (done_s && !st_q.done_prev)
      begin
         st_d.cal_busy = 1'b0; // RULE_20
      end

      st_d.rdata = reg_rd_in ? read_mux(reg_addr_in, st_q) : status_pkg::RDATA_IDLE;

      pending = {st_d.synth_fault & st_d.synth_pll_unlock_irq_en, // RULE_01
                 st_d.jitter_fault & st_d.jitter_pll_unlock_irq_en, // RULE_02
                 st_d.input_fault & st_d.input_los_irq_en, // RULE_03
                 st_d.ref_pend & st_d.reference_irq_en, // RULE_04
                 st_d.hold_fault & st_d.holdover_irq_en, // RULE_05
                 2'b00};
      st_d.irq_n = ~|pending; // RULE_22
   end

   // ---------------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_q <= '0;
         // Synchronisers start at the healthy level, so no false event or edge follows reset.
         st_q.sync1 <= status_pkg::RST_RAW;
         st_q.sync2 <= status_pkg::RST_RAW;
         st_q.ref_prev <= status_pkg::RST_REF_PREV;
         st_q.synth_pll_unlock_irq_en <= status_pkg::RST_IRQ_EN; // RULE_06
         st_q.jitter_pll_unlock_irq_en <= status_pkg::RST_IRQ_EN;
         st_q.input_los_irq_en <= {status_pkg::NUM_INPUTS{status_pkg::RST_IRQ_EN}};
         st_q.reference_irq_en <= status_pkg::RST_IRQ_EN;
         st_q.holdover_irq_en <= status_pkg::RST_IRQ_EN;
         st_q.synth_fault <= status_pkg::RST_FAULT;
         st_q.hold_fault <= status_pkg::RST_FAULT;
         st_q.polarity <= status_pkg::RST_POLARITY;
         st_q.rdata <= status_pkg::RDATA_IDLE;
         st_q.irq_n <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata_out = st_q.rdata;
   assign irq_n_out = st_q.irq_n;
   assign divider_init_out = st_q.init_pulse;
   assign pll_cmd_a_out = st_q.pll_cmd_a_pulse;
   assign bias_cal_cmd_out = st_q.cal_start;
   assign read_edge_polarity_out = st_q.polarity;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   property p_synth_irq;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      st_q.synth_fault && st_q.synth_pll_unlock_irq_en |-> !irq_n_out;
   endproperty
   a_synth_irq: assert property (p_synth_irq) else $error("synth unlock did not raise irq"); // RULE_01

   property p_jitter_irq;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      st_q.jitter_fault && st_q.jitter_pll_unlock_irq_en |-> !irq_n_out;
   endproperty
   a_jitter_irq: assert property (p_jitter_irq) else $error("jitter unlock did not raise irq"); // RULE_02

   property p_los_irq;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      |(st_q.input_fault & st_q.input_los_irq_en) |-> !irq_n_out;
   endproperty
   a_los_irq: assert property (p_los_irq) else $error("input loss did not raise irq"); // RULE_03

   property p_ref_change;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (ref_s != st_q.ref_prev) && st_q.reference_irq_en && !wr_ref_en |=> !irq_n_out;
   endproperty
   a_ref_change: assert property (p_ref_change) else $error("reference change did not raise irq"); // RULE_04

   property p_irq_quiet;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      !st_q.synth_pll_unlock_irq_en && !st_q.jitter_pll_unlock_irq_en && !(|st_q.input_los_irq_en)
      && !st_q.reference_irq_en && !st_q.holdover_irq_en |-> irq_n_out;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq low with all enables off"); // RULE_06

   property p_synth_sticky;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      !synth_lock_s |=> st_q.synth_fault;
   endproperty
   a_synth_sticky: assert property (p_synth_sticky) else $error("synth loss not latched"); // RULE_07

   property p_hold_sticky;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      st_q.hold_fault && !(wr_ref_clr && reg_wdata_in[status_pkg::BIT_HOLD]) |=> st_q.hold_fault;
   endproperty
   a_hold_sticky: assert property (p_hold_sticky) else $error("holdover flag lost without clear"); // RULE_11

   property p_sel_read;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      reg_rd_in && hit(reg_addr_in, status_pkg::OFF_NOW_LOCK_INPUTS)
      |=> reg_rdata_out[7:6] == $past(sel_s);
   endproperty
   a_sel_read: assert property (p_sel_read) else $error("selected input field wrong"); // RULE_12

   sequence s_pll_cmd_a_write;
      reg_wr_in && hit(reg_addr_in, status_pkg::OFF_PLL_CMD_A) && reg_wdata_in[status_pkg::BIT_COMMAND];
   endsequence
   sequence s_one_pulse;
      pll_cmd_a_out ##1 !pll_cmd_a_out;
   endsequence
   property p_pll_cmd_a;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      s_pll_cmd_a_write ##1 !reg_wr_in |-> s_one_pulse;
   endproperty
   a_pll_cmd_a: assert property (p_pll_cmd_a) else $error("pll_cmd_a pulse wrong"); // RULE_19

   property p_bias_busy;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      bias_cal_cmd_out |-> st_q.cal_busy;
   endproperty
   a_bias_busy: assert property (p_bias_busy) else $error("bias calibration not busy after start"); // RULE_20

   property p_polarity;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      wr_bias |=> read_edge_polarity_out == $past(reg_wdata_in[status_pkg::BIT_POLARITY]);
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity bit not stored"); // RULE_21

endmodule // pll_status_interrupt_regs

/* File: tb/bias_cal_model.sv */
// Behavioural model of the bias calibration engine that answers the start command.
`timescale 1ns/10ps
module bias_cal_model
#(
   parameter int DONE_DELAY = 20
)
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic bias_cal_cmd_in,
   output logic bias_cal_done_out
);
   // ---------------------------------------------------------------------
   // Calibration timer
   // ---------------------------------------------------------------------
   int cnt;
   // Done is held for several cycles so that the bank's synchroniser cannot miss it.
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt <= 0;
         bias_cal_done_out <= 1'b0;
      end
      else if (bias_cal_cmd_in && cnt == 0)
      begin
         cnt <= DONE_DELAY + 6;
         bias_cal_done_out <= 1'b0;
      end
      else if (cnt != 0)
      begin
         cnt <= cnt - 1;
         bias_cal_done_out <= (cnt <= 6) && (cnt > 1);
      end
   end
endmodule // bias_cal_model

/* File: tb/pll_status_interrupt_regs_tb.sv */
// Self-checking testbench for the status and control register bank.
`timescale 1ns/10ps
module pll_status_interrupt_regs_tb;
   // ---------------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------------
   logic core_clk_in, rst_n_in, reg_wr_in, reg_rd_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic synth_pll_lock_now_in, jitter_pll_lock_now_in, synth_cal_running_in;
   logic reference_present_now_in, holdover_now_in, bias_cal_done_in;
   logic [1:0] input_active_now_in, selected_input_now_in;
   logic irq_n_out, divider_init_out, pll_cmd_a_out, bias_cal_cmd_out, read_edge_polarity_out;
   logic [7:0] div_cnt, cmd_cnt, bias_cnt;
   int err_total, checks_done, cycles;
   logic [7:0] en_a [5] = '{8'h68, 8'h68, 8'h68, 8'h68, 8'h69};
   logic [7:0] st_a [5] = '{8'h6c, 8'h6c, 8'h6c, 8'h6c, 8'h6e};
   logic [7:0] mask [5] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h01};
   logic [7:0] idle [5] = '{8'h33, 8'h33, 8'h33, 8'h33, 8'h03};

   pll_status_interrupt_regs dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .synth_pll_lock_now_in(synth_pll_lock_now_in),
      .jitter_pll_lock_now_in(jitter_pll_lock_now_in), .input_active_now_in(input_active_now_in),
      .selected_input_now_in(selected_input_now_in), .synth_cal_running_in(synth_cal_running_in),
      .reference_present_now_in(reference_present_now_in), .holdover_now_in(holdover_now_in),
      .bias_cal_done_in(bias_cal_done_in), .irq_n_out(irq_n_out), .divider_init_out(divider_init_out),
      .pll_cmd_a_out(pll_cmd_a_out), .bias_cal_cmd_out(bias_cal_cmd_out),
      .read_edge_polarity_out(read_edge_polarity_out));

   bias_cal_model #(.DONE_DELAY(20)) partner_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .bias_cal_cmd_in(bias_cal_cmd_out), .bias_cal_done_out(bias_cal_done_in));

   // ---------------------------------------------------------------------
   // Clock, pulse counters and hang guard
   // ---------------------------------------------------------------------
   initial
   begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end

   // Counting pulses keeps the command checks independent of the exact launch cycle.
   always @(posedge core_clk_in)
   begin
      div_cnt <= div_cnt + {7'h00, divider_init_out === 1'b1};
      cmd_cnt <= cmd_cnt + {7'h00, pll_cmd_a_out === 1'b1};
      bias_cnt <= bias_cnt + {7'h00, bias_cal_cmd_out === 1'b1};
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------------
   task automatic tick();
      @(posedge core_clk_in);
      #1;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      tick();
      reg_wr_in = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      tick();
      reg_rd_in = 1'b0;
      check(reg_rdata_out, exp);
      tick();
   endtask

   task automatic set_src(input int i, input logic v);
      case (i)
         0: input_active_now_in[0] = v;
         1: input_active_now_in[1] = v;
         2: jitter_pll_lock_now_in = v;
         3: synth_pll_lock_now_in = v;
         default: holdover_now_in = v;
      endcase
   endtask

   task automatic wrap_up();
      if (err_total == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------------
   initial
   begin
      {rst_n_in, reg_wr_in, reg_rd_in, synth_cal_running_in} = 4'h0;
      {reg_addr_in, reg_wdata_in, div_cnt, cmd_cnt, bias_cnt} = 40'h0;
      {synth_pll_lock_now_in, jitter_pll_lock_now_in, reference_present_now_in, holdover_now_in} = 4'hf;
      input_active_now_in = 2'b11;
      selected_input_now_in = 2'b00;
      repeat (8) @(posedge core_clk_in);
      #1;
      rst_n_in = 1'b1;
      repeat (5) tick();
      wr(8'h6c, 8'h33);
      wr(8'h6e, 8'h03);
      rd(8'h68, 8'h00);
      rd(8'h69, 8'h00);
      rd(8'h6c, 8'h33);
      rd(8'h6e, 8'h03);
      rd(8'h73, 8'h00);
      check({7'h00, irq_n_out}, 8'h01);
      selected_input_now_in = 2'b01;
      jitter_pll_lock_now_in = 1'b0;
      input_active_now_in = 2'b10;
      synth_cal_running_in = 1'b1;
      holdover_now_in = 1'b0;
      repeat (4) tick();
      rd(8'h6d, 8'h62);
      rd(8'h6f, 8'h06);
      selected_input_now_in = 2'b00;
      {jitter_pll_lock_now_in, holdover_now_in} = 2'b11;
      input_active_now_in = 2'b11;
      {synth_cal_running_in, reference_present_now_in} = 2'b00;
      repeat (4) tick();
      rd(8'h6d, 8'h33);
      rd(8'h6f, 8'h01);
      reference_present_now_in = 1'b1;
      repeat (4) tick();
      wr(8'h6c, 8'h33);
      wr(8'h6e, 8'h03);
      for (int i = 0; i < 5; i++)
      begin
         set_src(i, 1'b0);
         repeat (5) tick();
         set_src(i, 1'b1);
         repeat (5) tick();
         check({7'h00, irq_n_out}, 8'h01);
         rd(st_a[i], idle[i] & ~mask[i]);
         wr(st_a[i], mask[i]);
         rd(st_a[i], idle[i]);
         wr(en_a[i], mask[i]);
         rd(en_a[i], mask[i]);
         set_src(i, 1'b0);
         repeat (5) tick();
         check({7'h00, irq_n_out}, 8'h00);
         set_src(i, 1'b1);
         repeat (5) tick();
         check({7'h00, irq_n_out}, 8'h00);
         wr(st_a[i], mask[i]);
         repeat (2) tick();
         check({7'h00, irq_n_out}, 8'h01);
         wr(en_a[i], 8'h00);
      end
      wr(8'h69, 8'h02);
      reference_present_now_in = 1'b0;
      repeat (5) tick();
      check({7'h00, irq_n_out}, 8'h00);
      rd(8'h6e, 8'h01);
      wr(8'h6e, 8'h02);
      repeat (3) tick();
      check({7'h00, irq_n_out}, 8'h01);
      reference_present_now_in = 1'b1;
      repeat (5) tick();
      check({7'h00, irq_n_out}, 8'h00);
      wr(8'h6e, 8'h02);
      repeat (3) tick();
      check({7'h00, irq_n_out}, 8'h01);
      rd(8'h6e, 8'h03);
      wr(8'h69, 8'h00);
      wr(8'h71, 8'h80);
      wr(8'h72, 8'h80);
      wr(8'h72, 8'h00);
      wr(8'h71, 8'h00);
      check(div_cnt, 8'h01);
      check(cmd_cnt, 8'h01);
      wr(8'h73, 8'h81);
      check({7'h00, read_edge_polarity_out}, 8'h01);
      rd(8'h73, 8'h81);
      wr(8'h73, 8'h81);
      check(bias_cnt, 8'h01);
      repeat (30) tick();
      rd(8'h73, 8'h01);
      wr(8'h73, 8'h80);
      check(bias_cnt, 8'h02);
      rd(8'h73, 8'h80);
      check({7'h00, read_edge_polarity_out}, 8'h00);
      repeat (30) tick();
      rd(8'h73, 8'h00);
      wr(8'h70, 8'hff);
      rd(8'h70, 8'h00);
      rd(8'h68, 8'h00);
      wr(8'h68, 8'h33);
      wr(8'h73, 8'h01);
      synth_pll_lock_now_in = 1'b0;
      repeat (5) tick();
      check({7'h00, irq_n_out}, 8'h00);
      rst_n_in = 1'b0;
      repeat (2) tick();
      synth_pll_lock_now_in = 1'b1;
      rst_n_in = 1'b1;
      check({7'h00, irq_n_out}, 8'h01);
      repeat (3) tick();
      rd(8'h68, 8'h00);
      rd(8'h6c, 8'h33);
      rd(8'h6e, 8'h03);
      rd(8'h73, 8'h00);
      check({7'h00, irq_n_out}, 8'h01);
      wrap_up();
   end
endmodule // pll_status_interrupt_regs_tb
